// ---- verilog/pwm_timer.sv ----
// 16-bit PWM timer/counter with three compare channels and shadowed limits
//
// Contract
// - Three waveform outputs; three more only in split mode, here held low.
// - Counter ticks come from the module clock through an own prescaler.
// - Debug halt stops the block unless run_while_halted is set.
// - BOTTOM is zero, MAX all ones, TOP the sequence's highest value.
// - Update happens at BOTTOM or TOP depending on waveform mode.
// - After enable is set, counter counts prescaled ticks.
// - With count_on_event_enable set, event inputs are counted instead.
// - Normal mode direction follows up/down bit, changeable while running.
// - Counting up at TOP wraps to zero on next tick.
// - Counting down at BOTTOM reloads the top limit.
// - Software counter write is immediate and beats count, clear, reload.
// - Top and compare shadows have valid flags set on write, cleared on update.
// - Active and shadow values are both directly writable.
// - Direct top limit write changes period immediately.
// - Top compared continuously; lower top while counting up wraps via MAX.
// - With shadow written, active top changes only on update.
// - Compare match sets channel flag on next timer tick; interrupt if enabled.
// - Compare shadows move to active only on update.
// - Pin override needs waveform mode, clock counting and channel enable.
// - Each waveform output can be routed to an alternative pin.
// - Frequency mode: compare sets period, output toggles on every match.
// - Frequency mode, compare zero, no prescale: toggles every clock.
// - Single-slope: count up to TOP, set at TOP, clear on match.
// - Dual-slope: up then down; set at BOTTOM, clear up-match, set down-match.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module pwm_timer
   import pwm_timer_pkg::*;
#(
   parameter int PRESCALE_W = PRESCALE_WIDTH
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic debug_halt,
   input wire logic event_in,
   output logic [CHANNELS-1:0] waveform_out,
   output logic [CHANNELS-1:0] waveform_oe,
   output logic [CHANNELS-1:0] waveform_out_split,
   output logic [CHANNELS-1:0] alt_pin_select,
   output logic irq
);

   // ----------------------------------------
   // Control state
   // ----------------------------------------
   logic enable;
   logic [2:0] clock_prescale_select;
   wg_mode_e waveform_mode_select;
   logic [CHANNELS-1:0] compare_output_enable;
   logic dir_down;
   logic count_on_event_enable;
   logic run_while_halted;
   logic [3:0] flags;
   logic [3:0] flag_mask;
   logic [15:0] counter_value;
   logic [15:0] top_limit;
   logic [15:0] top_limit_shadow;
   logic top_shadow_valid;
   logic slope_down;
   logic [PRESCALE_W-1:0] prescale_count;
   logic [CHANNELS-1:0][15:0] compare_vec;
   logic [CHANNELS-1:0][15:0] shadow_vec;
   logic [CHANNELS-1:0] compare_shadow_valid;
   logic [CHANNELS-1:0] match;
   logic [CHANNELS-1:0] wr_cmp;
   logic [CHANNELS-1:0] wr_cmp_shadow;

   // ----------------------------------------
   // Decode and tick generation
   // ----------------------------------------
   logic wr_ctrl_a, wr_ctrl_b, wr_ctrl_e, wr_evctl, wr_dbg, wr_mux;
   logic wr_flags, wr_mask, wr_cnt, wr_top, wr_top_shadow;
   logic run, prescale_tick, tick, count_down, at_top, at_bottom, update;
   logic [PRESCALE_W-1:0] prescale_mask;
   logic [15:0] top_eff;
   logic [15:0] next_count;

   assign wr_ctrl_a = wr && addr == OFS_CONTROL_A;
   assign wr_ctrl_b = wr && addr == OFS_CONTROL_B;
   assign wr_ctrl_e = wr && addr == OFS_CONTROL_E;
   assign wr_evctl = wr && addr == OFS_EVENT_CONTROL;
   assign wr_dbg = wr && addr == OFS_DEBUG_CONTROL;
   assign wr_mux = wr && addr == OFS_PORT_MULTIPLEXER;
   assign wr_flags = wr && addr == OFS_FLAGS;
   assign wr_mask = wr && addr == OFS_FLAG_MASK;
   assign wr_cnt = wr && addr == OFS_COUNTER_VALUE;
   assign wr_top = wr && addr == OFS_TOP_LIMIT;
   assign wr_top_shadow = wr && addr == OFS_TOP_LIMIT_SHADOW;

   assign run = enable && (!debug_halt || run_while_halted);
   assign prescale_mask =
      PRESCALE_W'((1 << prescale_shift(clock_prescale_select)) - 1);
   assign prescale_tick = (prescale_count & prescale_mask) == prescale_mask;
   assign tick = run && (count_on_event_enable ? event_in : prescale_tick);

   // Prescaler restarts whenever the timer stops, so phase is repeatable
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         prescale_count <= '0;
      else if (!run)
         prescale_count <= '0;
      else
         prescale_count <= prescale_count + 1'b1;
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // Frequency mode takes its period from channel 0
   assign top_eff = (waveform_mode_select == wg_frq) ? compare_vec[0] : top_limit;
   assign count_down = (waveform_mode_select == wg_dual) ? slope_down :
      (waveform_mode_select == wg_normal) ? dir_down : 1'b0;
   // Equality only: a top below the count is passed and wraps via MAX
   assign at_top = counter_value == top_eff;
   assign at_bottom = counter_value == 16'h0000;
   assign update = tick && ((waveform_mode_select == wg_dual) ? (slope_down && at_bottom) :
      count_down ? at_bottom : at_top);

   always_comb
   begin
      next_count = counter_value + 16'h0001;
      if (waveform_mode_select == wg_dual)
      begin
         if (!slope_down)
            next_count = at_top ? counter_value - 16'h0001 : counter_value + 16'h0001;
         else
            next_count = at_bottom ? counter_value + 16'h0001 : counter_value - 16'h0001;
      end
      else if (count_down)
         next_count = at_bottom ? top_eff : counter_value - 16'h0001;
      else
         next_count = at_top ? 16'h0000 : counter_value + 16'h0001;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         counter_value <= COUNT_RESET;
      else if (wr_cnt)
         counter_value <= wdata;
      else if (tick)
         counter_value <= next_count;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         slope_down <= 1'b0;
      else if (waveform_mode_select != wg_dual)
         slope_down <= 1'b0;
      else if (tick && !wr_cnt)
      begin
         if (!slope_down && at_top)
            slope_down <= 1'b1;
         else if (slope_down && at_bottom)
            slope_down <= 1'b0;
      end
   end

   // ----------------------------------------
   // Top limit and its shadow
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         top_limit <= TOP_RESET;
         top_limit_shadow <= TOP_RESET;
         top_shadow_valid <= 1'b0;
      end
      else
      begin
         if (wr_top)
            top_limit <= wdata;
         else if (update && top_shadow_valid)
            top_limit <= top_limit_shadow;
         if (wr_top_shadow)
            top_limit_shadow <= wdata;
         // A write in the update cycle keeps the flag set
         if (wr_top_shadow)
            top_shadow_valid <= 1'b1;
         else if (update)
            top_shadow_valid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Compare channels
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < CHANNELS; i++)
      begin : channel
         logic [15:0] value;
         logic [15:0] shadow;
         logic valid;
         logic wave;

         assign wr_cmp[i] = wr && addr == OFS_COMPARE_VALUE + 5'(i);
         assign wr_cmp_shadow[i] = wr && addr == OFS_COMPARE_SHADOW + 5'(i);
         assign match[i] = counter_value == value;
         assign compare_vec[i] = value;
         assign shadow_vec[i] = shadow;
         assign compare_shadow_valid[i] = valid;
         assign waveform_out[i] = wave;
         assign waveform_oe[i] = (waveform_mode_select != wg_normal) &&
            !count_on_event_enable && compare_output_enable[i];

         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               value <= COMPARE_RESET;
               shadow <= COMPARE_RESET;
               valid <= 1'b0;
            end
            else
            begin
               if (wr_cmp[i])
                  value <= wdata;
               else if (update && valid)
                  value <= shadow;
               if (wr_cmp_shadow[i])
                  shadow <= wdata;
               if (wr_cmp_shadow[i])
                  valid <= 1'b1;
               else if (update)
                  valid <= 1'b0;
            end
         end

         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               wave <= 1'b0;
            else if (tick)
            begin
               case (waveform_mode_select)
                  wg_frq:
                     if (match[i])
                        wave <= !wave;
                  wg_single:
                     if (at_top)
                        wave <= 1'b1;
                     else if (match[i])
                        wave <= 1'b0;
                  wg_dual:
                     if (slope_down && at_bottom)
                        wave <= 1'b1;
                     else if (match[i])
                        wave <= slope_down;
                  default:
                     wave <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // No split mode: the upper outputs never drive
   assign waveform_out_split = '0;

   // ----------------------------------------
   // Flags and interrupt
   // ----------------------------------------
   logic [3:0] flag_set;
   logic [3:0] flag_clear;

   assign flag_set = {update, tick ? match : 3'b000};
   assign flag_clear = wr_flags ? wdata[3:0] : 4'h0;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         flags <= 4'h0;
      else
         flags <= (flags & ~flag_clear) | flag_set;
   end

   assign irq = |(flags & flag_mask);

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         enable <= 1'b0;
         clock_prescale_select <= 3'h0;
         waveform_mode_select <= wg_normal;
         compare_output_enable <= '0;
         dir_down <= 1'b0;
         count_on_event_enable <= 1'b0;
         run_while_halted <= 1'b0;
         alt_pin_select <= '0;
         flag_mask <= 4'h0;
      end
      else
      begin
         if (wr_ctrl_a)
         begin
            enable <= wdata[ENABLE_BIT];
            clock_prescale_select <= wdata[CLOCK_PRESCALE_SELECT_LSB +: 3];
         end
         if (wr_ctrl_b)
         begin
            waveform_mode_select <= wg_mode_e'(wdata[WAVEFORM_MODE_SELECT_LSB +: 2]);
            compare_output_enable <= wdata[CMPEN_LSB +: CHANNELS];
         end
         if (wr_ctrl_e)
            dir_down <= wdata[DIR_BIT];
         if (wr_evctl)
            count_on_event_enable <= wdata[0];
         if (wr_dbg)
            run_while_halted <= wdata[0];
         if (wr_mux)
            alt_pin_select <= wdata[CHANNELS-1:0];
         if (wr_mask)
            flag_mask <= wdata[3:0];
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [15:0] read_value;
   logic [1:0] cmp_idx;
   logic [1:0] shadow_idx;

   assign cmp_idx = 2'(addr - OFS_COMPARE_VALUE);
   assign shadow_idx = 2'(addr - OFS_COMPARE_SHADOW);

   always_comb
   begin
      read_value = 16'h0000;
      if (addr == OFS_CONTROL_A)
         read_value = {12'h000, clock_prescale_select, enable};
      else if (addr == OFS_CONTROL_B)
         read_value = {9'h000, compare_output_enable, 2'b00, waveform_mode_select};
      else if (addr == OFS_CONTROL_E)
         read_value = {15'h0000, dir_down};
      else if (addr == OFS_CONTROL_F)
         read_value = {12'h000, compare_shadow_valid, top_shadow_valid};
      else if (addr == OFS_EVENT_CONTROL)
         read_value = {15'h0000, count_on_event_enable};
      else if (addr == OFS_DEBUG_CONTROL)
         read_value = {15'h0000, run_while_halted};
      else if (addr == OFS_PORT_MULTIPLEXER)
         read_value = {13'h0000, alt_pin_select};
      else if (addr == OFS_FLAGS)
         read_value = {12'h000, flags};
      else if (addr == OFS_FLAG_MASK)
         read_value = {12'h000, flag_mask};
      else if (addr == OFS_COUNTER_VALUE)
         read_value = counter_value;
      else if (addr == OFS_TOP_LIMIT)
         read_value = top_limit;
      else if (addr == OFS_TOP_LIMIT_SHADOW)
         read_value = top_limit_shadow;
      else if (addr >= OFS_COMPARE_VALUE && addr < OFS_COMPARE_VALUE + 5'(CHANNELS))
         read_value = compare_vec[cmp_idx];
      else if (addr >= OFS_COMPARE_SHADOW && addr < OFS_COMPARE_SHADOW + 5'(CHANNELS))
         read_value = shadow_vec[shadow_idx];
   end

   // Data stand one cycle only, zero otherwise
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata <= 16'h0000;
      else if (rd)
         rdata <= read_value;
      else
         rdata <= 16'h0000;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   cnt_write_a: assert property (wr_cnt |=> counter_value == $past(wdata))
      else $error("counter write not immediate");
   halt_freeze_a: assert property (enable && debug_halt && !run_while_halted && !wr_cnt
      |=> $stable(counter_value))
      else $error("counter moved while halted");
   up_wrap_a: assert property (tick && !wr_cnt && waveform_mode_select == wg_normal
      && !dir_down && at_top |=> counter_value == 16'h0000)
      else $error("no wrap at top");
   down_reload_a: assert property (tick && !wr_cnt && waveform_mode_select == wg_normal
      && dir_down && at_bottom |=> counter_value == $past(top_limit))
      else $error("no reload at bottom");
   cmp_flag_a: assert property (tick && match[0] |=> flags[0])
      else $error("compare flag not set");
   pin_override_a: assert property (waveform_oe[1] |-> compare_output_enable[1]
      && !count_on_event_enable && waveform_mode_select != wg_normal)
      else $error("override without its conditions");
   top_xfer_a: assert property (update && top_shadow_valid && !wr_top && !wr_top_shadow
      |=> top_limit == $past(top_limit_shadow) && !top_shadow_valid)
      else $error("top shadow not transferred");
   top_hold_a: assert property (!update && !wr_top |=> $stable(top_limit))
      else $error("top changed outside update");
   shadow_valid_a: assert property (wr_cmp_shadow[2] |=> compare_shadow_valid[2])
      else $error("shadow valid not set");
   frq_toggle_a: assert property (waveform_mode_select == wg_frq && tick && match[0]
      |=> waveform_out[0] != $past(waveform_out[0]))
      else $error("no toggle on match");
   no_prescale_a: assert property (run && clock_prescale_select == 3'h0
      && !count_on_event_enable |-> tick)
      else $error("undivided tick missing");
   fast_frq_a: assert property ((waveform_mode_select == wg_frq && compare_vec[0] == 16'h0000
      && counter_value == 16'h0000 && tick) [*2]
      |-> waveform_out[0] != $past(waveform_out[0]))
      else $error("frequency output not toggling each clock");

   frq_run_c: cover property (waveform_mode_select == wg_frq && tick && match[0]);
   dual_turn_c: cover property (waveform_mode_select == wg_dual && tick && at_top
      ##[1:200] slope_down && at_bottom && tick);
   cmp_xfer_c: cover property (update && compare_shadow_valid[0]);
   halted_run_c: cover property (debug_halt && run_while_halted && tick);

endmodule

// ---- verilog/pwm_timer_pkg.sv ----
// Package: register map, field layout and mode codes of the 16-bit PWM timer
package pwm_timer_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int CHANNELS = 3;
   localparam int PRESCALE_WIDTH = 10;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [4:0] OFS_CONTROL_A = 5'h00;
   localparam logic [4:0] OFS_CONTROL_B = 5'h01;
   localparam logic [4:0] OFS_CONTROL_E = 5'h02;
   localparam logic [4:0] OFS_CONTROL_F = 5'h03;
   localparam logic [4:0] OFS_EVENT_CONTROL = 5'h04;
   localparam logic [4:0] OFS_DEBUG_CONTROL = 5'h05;
   localparam logic [4:0] OFS_PORT_MULTIPLEXER = 5'h06;
   localparam logic [4:0] OFS_FLAGS = 5'h07;
   localparam logic [4:0] OFS_FLAG_MASK = 5'h08;
   localparam logic [4:0] OFS_COUNTER_VALUE = 5'h10;
   localparam logic [4:0] OFS_TOP_LIMIT = 5'h11;
   localparam logic [4:0] OFS_TOP_LIMIT_SHADOW = 5'h12;
   localparam logic [4:0] OFS_COMPARE_VALUE = 5'h14;
   localparam logic [4:0] OFS_COMPARE_SHADOW = 5'h18;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ENABLE_BIT = 0;
   localparam int CLOCK_PRESCALE_SELECT_LSB = 1;
   localparam int WAVEFORM_MODE_SELECT_LSB = 0;
   localparam int CMPEN_LSB = 4;
   localparam int DIR_BIT = 0;
   localparam int OVF_FLAG_BIT = 3;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] TOP_RESET = 16'hffff;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COMPARE_RESET = 16'h0000;

   typedef enum logic [1:0] {
      wg_normal = 2'b00,
      wg_frq = 2'b01,
      wg_single = 2'b10,
      wg_dual = 2'b11
   } wg_mode_e;

   // Divide by 1,2,4,8,16,64,256,1024
   function automatic int prescale_shift(input logic [2:0] sel);
      int s;
      s = 0;
      case (sel)
         3'h0: s = 0;
         3'h1: s = 1;
         3'h2: s = 2;
         3'h3: s = 3;
         3'h4: s = 4;
         3'h5: s = 6;
         3'h6: s = 8;
         default: s = 10;
      endcase
      return s;
   endfunction

endpackage

// ---- verification/pin_event_model.sv ----
// Far-side model: event source bursts and port pins driven by the timer
`timescale 1ns/10ps
module pin_event_model
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [7:0] burst,
   input wire logic [2:0] wo,
   input wire logic [2:0] oe,
   input wire logic [2:0] port_out,
   output logic event_out,
   output logic [2:0] pin
);
   logic [7:0] left;

   // Burst of back-to-back event cycles, first one right after start
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         left <= 8'h00;
         event_out <= 1'b0;
      end
      else if (start)
      begin
         left <= burst;
         event_out <= burst != 8'h00;
      end
      else
      begin
         left <= (left != 8'h00) ? left - 8'h01 : 8'h00;
         event_out <= left > 8'h01;
      end
   end

   // Port output register shows through wherever the timer has no override
   assign pin = (oe & wo) | (~oe & port_out);
endmodule

// ---- verification/pwm_timer_test.sv ----
// Self-checking bench for the 16-bit PWM timer
`timescale 1ns/10ps
module pwm_timer_test;
   import pwm_timer_pkg::*;

   typedef struct {logic [4:0] wa; logic [15:0] wd; logic [4:0] ra; logic [15:0] exp;} row_s;
   logic clk, rstn, wr, rd, debug_halt, start;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, v;
   logic [7:0] burst;
   logic event_in, prev;
   logic [2:0] wo, oe, split, alt, pin;
   logic irq;
   int miscompares, comparisons, n;
   row_s rows [15];

   pwm_timer dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .debug_halt(debug_halt), .event_in(event_in), .waveform_out(wo),
      .waveform_oe(oe), .waveform_out_split(split), .alt_pin_select(alt), .irq(irq));
   pin_event_model far_u (.clk(clk), .rstn(rstn), .start(start), .burst(burst), .wo(wo),
      .oe(oe), .port_out(3'b110), .event_out(event_in), .pin(pin));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rreg(a, d);
      check(what, exp, d);
   endtask

   // Event bursts keep counts exact, unlike free-running clock ticks
   task automatic pulse(input logic [7:0] k);
      @(posedge clk);
      start <= 1'b1;
      burst <= k;
      @(posedge clk);
      start <= 1'b0;
      repeat (k + 1) @(posedge clk);
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
   endtask

   // Bounded wait for the channel 0 waveform to change
   task automatic wait_toggle(output int c);
      prev = wo[0];
      c = 0;
      while (wo[0] === prev)
      begin
         @(negedge clk);
         c++;
         if (c > 40)
         begin
            miscompares++;
            tally_and_finish();
         end
      end
   endtask

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rstn, wr, rd, debug_halt, start, addr, wdata, burst} = '0;
      rows = '{
         '{5'h00, 16'hffff, 5'h00, 16'h000f},
         '{5'h01, 16'hffff, 5'h01, 16'h0073},
         '{5'h02, 16'hffff, 5'h02, 16'h0001},
         '{5'h04, 16'hffff, 5'h04, 16'h0001},
         '{5'h05, 16'hffff, 5'h05, 16'h0001},
         '{5'h06, 16'hffff, 5'h06, 16'h0007},
         '{5'h00, 16'h0000, 5'h00, 16'h0000},
         '{5'h12, 16'h4321, 5'h03, 16'h0001},
         '{5'h18, 16'h0011, 5'h03, 16'h0003},
         '{5'h1a, 16'h0022, 5'h03, 16'h000b},
         '{5'h03, 16'h0000, 5'h03, 16'h000b},
         '{5'h11, 16'h1234, 5'h11, 16'h1234},
         '{5'h14, 16'hbeef, 5'h14, 16'hbeef},
         '{5'h16, 16'h0033, 5'h1a, 16'h0022},
         '{5'h1f, 16'hffff, 5'h1f, 16'h0000}};
      do_reset();
      rchk("top reset", 5'h11, 16'hffff);
      rchk("count reset", 5'h10, 16'h0000);
      check("split outputs", 16'h0000, {13'h0, split});
      $display("reset test done");
      foreach (rows[i])
      begin
         wreg(rows[i].wa, rows[i].wd);
         rchk("register row", rows[i].ra, rows[i].exp);
      end
      check("alt pin select", 16'h0007, {13'h0, alt});
      $display("register rows done");

      // Event counting, wrap, flags, halt, direction and write priority
      do_reset();
      wreg(5'h11, 16'h0002);
      wreg(5'h04, 16'h0001);
      wreg(5'h00, 16'h0001);
      pulse(3);
      rchk("wrap to zero", 5'h10, 16'h0000);
      rchk("flags", 5'h07, 16'h000f);
      check("irq masked", 16'h0000, {15'h0, irq});
      wreg(5'h08, 16'h0008);
      @(negedge clk);
      check("irq", 16'h0001, {15'h0, irq});
      wreg(5'h07, 16'h000f);
      rchk("flags cleared", 5'h07, 16'h0000);
      debug_halt <= 1'b1;
      pulse(2);
      rchk("halted count", 5'h10, 16'h0000);
      wreg(5'h05, 16'h0001);
      pulse(2);
      rchk("run while halted", 5'h10, 16'h0002);
      debug_halt <= 1'b0;
      wreg(5'h02, 16'h0001);
      wreg(5'h10, 16'h0000);
      pulse(1);
      rchk("down reload", 5'h10, 16'h0002);
      pulse(1);
      rchk("down count", 5'h10, 16'h0001);
      @(posedge clk);
      start <= 1'b1;
      burst <= 8'h01;
      @(posedge clk);
      start <= 1'b0;
      addr <= 5'h10;
      wdata <= 16'h0007;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rchk("count write wins", 5'h10, 16'h0007);
      wreg(5'h02, 16'h0000);
      wreg(5'h10, 16'h0000);
      wreg(5'h12, 16'h0005);
      rchk("top shadow valid", 5'h03, 16'h0001);
      pulse(2);
      rchk("top held", 5'h11, 16'h0002);
      pulse(1);
      rchk("top updated", 5'h11, 16'h0005);
      rchk("top shadow spent", 5'h03, 16'h0000);
      wreg(5'h10, 16'h000a);
      wreg(5'h11, 16'h0003);
      pulse(1);
      rchk("count past low top", 5'h10, 16'h000b);
      $display("counter test done");

      // Single-slope PWM on events
      do_reset();
      wreg(5'h11, 16'h0003);
      wreg(5'h14, 16'h0001);
      wreg(5'h01, 16'h0012);
      wreg(5'h04, 16'h0001);
      wreg(5'h00, 16'h0001);
      check("no override on events", 16'h0000, {13'h0, oe});
      pulse(4);
      check("set at top", 16'h0001, {15'h0, wo[0]});
      pulse(2);
      check("clear on match", 16'h0000, {15'h0, wo[0]});
      $display("single slope test done");

      // Dual-slope PWM on events; compare shadow moves only at BOTTOM
      do_reset();
      wreg(5'h11, 16'h0003);
      wreg(5'h14, 16'h0001);
      wreg(5'h18, 16'h0002);
      wreg(5'h01, 16'h0003);
      wreg(5'h04, 16'h0001);
      wreg(5'h00, 16'h0001);
      pulse(6);
      check("set on down match", 16'h0001, {15'h0, wo[0]});
      rchk("compare held", 5'h14, 16'h0001);
      pulse(1);
      rchk("compare updated", 5'h14, 16'h0002);
      pulse(2);
      check("clear on up match", 16'h0000, {15'h0, wo[0]});
      rchk("dual count", 5'h10, 16'h0003);
      $display("dual slope test done");

      // Frequency mode on clock ticks
      do_reset();
      wreg(5'h01, 16'h0011);
      wreg(5'h00, 16'h0001);
      @(negedge clk);
      check("override", 16'h0001, {13'h0, oe});
      check("pin", {13'h0, 2'b11, wo[0]}, {13'h0, pin});
      for (int i = 0; i < 6; i++)
      begin
         prev = wo[0];
         @(negedge clk);
         check("half clock toggle", {15'h0, ~prev}, {15'h0, wo[0]});
      end
      wreg(5'h14, 16'h0002);
      wait_toggle(n);
      wait_toggle(n);
      check("toggle period", 16'h0003, n[15:0]);
      $display("frequency test done");

      // Prescaler divide by four
      do_reset();
      wreg(5'h00, 16'h0005);
      repeat (40) @(posedge clk);
      wreg(5'h00, 16'h0000);
      rreg(5'h10, v);
      check("prescaled count", 16'h0001, {15'h0, v >= 16'h0009 && v <= 16'h000b});
      $display("prescaler test done");
      tally_and_finish();
   end
endmodule
